// ==== inc/ext_irq_pkg.sv ====
/*
 * Shared constants and carriers for the external interrupt detection
 * configuration block: register offsets, reset values, field positions,
 * sense modes and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package ext_irq_pkg;

    localparam int          ADDR_W          = 8;
    localparam int          N_EXT           = 6;
    localparam int          N_PORT          = 16;
    localparam int          N_ENC           = 4;

    localparam logic [7:0]  OFS_EXT_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_PORT_SENSE  = 8'h04;
    localparam logic [7:0]  OFS_PORT_EN     = 8'h08;
    localparam logic [7:0]  OFS_REQ_FLAG    = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_STAT    = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h14;

    localparam logic [15:0] EXT_CTRL_RST    = 16'h4000;
    localparam logic [15:0] PORT_SENSE_RST  = 16'h0000;
    localparam logic [15:0] PORT_EN_RST     = 16'h0000;
    localparam logic [7:0]  IRQ_MASK_RST    = 8'h00;
    localparam logic [15:0] EXT_CTRL_WMASK  = 16'hEFFF;

    localparam int          BIT_MASK_ALL    = 15;
    localparam int          BIT_LVL         = 14;
    localparam int          BIT_BLOCK_MASK  = 13;
    localparam int          BIT_RSVD        = 12;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [1:0] {
        SENSE_FALL = 2'b00,
        SENSE_RISE = 2'b01,
        SENSE_LOW  = 2'b10,
        SENSE_HIGH = 2'b11
    } sense_t;

    typedef struct packed {
        logic        mask_all_on_nmi_low;
        logic        lvl;
        logic        block_bit_mask_control;
        logic        rsvd;
        logic [11:0] sense;
    } ext_ctrl_t;

    typedef struct packed {
        logic       mask_all;
        logic       nmi_mask;
        logic       encode_on;
        logic [3:0] level;
    } core_ctrl_t;

endpackage : ext_irq_pkg

// ==== core/sync2.sv ====
/*
 * Two-flop synchroniser for a vector of independent level inputs.
 * Assumes each bit is a slow level; no bus coherence is implied.
 */
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : sync2

`default_nettype wire

// ==== core/ext_pin_detect.sv ====
/*
 * Detection of one external request pin: falling or rising edge with a
 * sticky flag, or low or high level followed directly.
 * Assumes pin is already synchronised to clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

module ext_pin_detect (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // pin and controls
    input  wire logic       pin,
    input  wire logic [1:0] mode,
    input  wire logic       enable,
    input  wire logic       clr,
    // request
    output logic            flag_q
);

    logic prev_q;
    logic hit;

    always_comb begin
        case (ext_irq_pkg::sense_t'(mode))
            ext_irq_pkg::SENSE_FALL: hit = prev_q & ~pin;
            ext_irq_pkg::SENSE_RISE: hit = ~prev_q & pin;
            ext_irq_pkg::SENSE_LOW:  hit = ~pin;
            ext_irq_pkg::SENSE_HIGH: hit = pin;
            default:                 hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= pin;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flag_q <= 1'b0;
        end else if (!enable) begin
            flag_q <= 1'b0;
        end else if (mode[1]) begin
            flag_q <= hit;
        end else if (hit) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end

endmodule : ext_pin_detect

`default_nettype wire

// ==== core/ext_irq_detect_config.sv ====
/*
 * Detection configuration for six external request pins and sixteen
 * port interrupt pins, with an AXI4-Lite register slave and a
 * maskable summary interrupt.
 * Assumes pins are asynchronous; cpu_block_bit and standby_mode come
 * from logic on clk_sys. Priority and vector logic live elsewhere.
 */
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module ext_irq_detect_config #(
    parameter int N_EXT  = ext_irq_pkg::N_EXT,
    parameter int N_PORT = ext_irq_pkg::N_PORT
) (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          resetn,
    // axi4-lite write
    input  wire logic [ext_irq_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    // axi4-lite read
    input  wire logic [ext_irq_pkg::ADDR_W-1:0] araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    // pins
    input  wire logic [N_EXT-1:0]              ext_request_pins,
    input  wire logic [N_PORT-1:0]             port_interrupt_pins,
    input  wire logic                          nmi_pin,
    // cpu core side
    input  wire logic                          cpu_block_bit,
    input  wire logic                          standby_mode,
    output logic [N_EXT-1:0]                   ext_request_flag,
    output logic [N_PORT-1:0]                  port_request_q,
    output ext_irq_pkg::core_ctrl_t            core_ctrl_q,
    // summary interrupt
    output logic                               irq
);

    if (N_EXT != ext_irq_pkg::N_EXT || N_PORT != ext_irq_pkg::N_PORT) begin : g_chk
        $error("field layout only serves six request and sixteen port pins");
    end

    ext_irq_pkg::ext_ctrl_t  ext_ctrl_q;
    logic [15:0]             port_sense_q;
    logic [15:0]             port_en_q;
    logic [7:0]              stat_q;
    logic [7:0]              mask_q;
    logic [N_EXT-1:0]        armed_q;
    logic [N_EXT-1:0]        flag_prev_q;
    logic [1:0]              grp_prev_q;
    logic [N_EXT-1:0]        ext_s;
    logic [N_PORT-1:0]       port_s;
    logic                    nmi_s;
    logic [N_EXT-1:0]        clr;
    logic [1:0]              grp;
    logic [7:0]              events;
    logic                              aw_hold_q;
    logic                              w_hold_q;
    logic [ext_irq_pkg::ADDR_W-1:0]    waddr_q;
    logic [31:0]                       wdata_q;
    logic [3:0]                        wstrb_q;
    logic                              do_write;
    logic                              rd_take;
    logic [31:0]                       rd_word;
    logic                              rd_hit;
    logic                              wr_hit;
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction : merge16

    sync2 #(.W(N_EXT)) u_sync_ext (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .d       (ext_request_pins),
        .q       (ext_s)
    );

    sync2 #(.W(N_PORT)) u_sync_port (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .d       (port_interrupt_pins),
        .q       (port_s)
    );

    sync2 #(.W(1)) u_sync_nmi (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .d       (nmi_pin),
        .q       (nmi_s)
    );

    // write channel: address and data taken in either order
    assign awready  = ~aw_hold_q & ~bvalid;
    assign wready   = ~w_hold_q & ~bvalid;
    assign do_write = aw_hold_q & w_hold_q & ~bvalid;
    assign arready  = ~rvalid;
    assign rd_take  = arvalid & arready;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            waddr_q   <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_hold_q <= 1'b1;
                waddr_q   <= awaddr;
            end else if (do_write) begin
                aw_hold_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end else if (do_write) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    always_comb begin
        case (waddr_q)
            ext_irq_pkg::OFS_EXT_CTRL,
            ext_irq_pkg::OFS_PORT_SENSE,
            ext_irq_pkg::OFS_PORT_EN,
            ext_irq_pkg::OFS_REQ_FLAG,
            ext_irq_pkg::OFS_IRQ_STAT,
            ext_irq_pkg::OFS_IRQ_MASK: wr_hit = 1'b1;
            default:                   wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bvalid <= 1'b0;
            bresp  <= ext_irq_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? ext_irq_pkg::RESP_OKAY : ext_irq_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ext_ctrl_q   <= ext_irq_pkg::ext_ctrl_t'(ext_irq_pkg::EXT_CTRL_RST);
            port_sense_q <= ext_irq_pkg::PORT_SENSE_RST;
            port_en_q    <= ext_irq_pkg::PORT_EN_RST;
            mask_q       <= ext_irq_pkg::IRQ_MASK_RST;
        end else if (do_write) begin
            case (waddr_q)
                ext_irq_pkg::OFS_EXT_CTRL: begin
                    ext_ctrl_q <= ext_irq_pkg::ext_ctrl_t'(ext_irq_pkg::EXT_CTRL_WMASK
                        & merge16(ext_ctrl_q, wdata_q, wstrb_q));
                end
                ext_irq_pkg::OFS_PORT_SENSE: begin
                    port_sense_q <= merge16(port_sense_q, wdata_q, wstrb_q);
                end
                ext_irq_pkg::OFS_PORT_EN: begin
                    port_en_q <= merge16(port_en_q, wdata_q, wstrb_q);
                end
                ext_irq_pkg::OFS_IRQ_MASK: begin
                    if (wstrb_q[0]) begin
                        mask_q <= wdata_q[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // a zero written to an edge-mode flag clears it only after it was read as one
    always_comb begin
        clr = '0;
        if (do_write && waddr_q == ext_irq_pkg::OFS_REQ_FLAG && wstrb_q[0]) begin
            clr = armed_q & ~wdata_q[N_EXT-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            armed_q <= '0;
        end else if (rd_take && araddr == ext_irq_pkg::OFS_REQ_FLAG) begin
            armed_q <= ext_request_flag;
        end else if (do_write && waddr_q == ext_irq_pkg::OFS_REQ_FLAG) begin
            armed_q <= '0;
        end
    end

    // per-pin detection, encoded pins drop out of the independent flags
    for (genvar n = 0; n < N_EXT; n++) begin : g_ext
        ext_pin_detect u_det (
            .clk_sys (clk_sys),
            .resetn  (resetn),
            .pin     (ext_s[n]),
            .mode    (ext_ctrl_q.sense[2*n+1 -: 2]),
            .enable  (!(ext_ctrl_q.lvl && n < ext_irq_pkg::N_ENC)),
            .clr     (clr[n]),
            .flag_q  (ext_request_flag[n])
        );
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            port_request_q <= '0;
        end else begin
            port_request_q <= port_en_q & ~(port_s ^ port_sense_q);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            core_ctrl_q <= '0;
        end else begin
            core_ctrl_q.mask_all  <= ext_ctrl_q.mask_all_on_nmi_low & ~nmi_s;
            core_ctrl_q.nmi_mask  <= (ext_ctrl_q.mask_all_on_nmi_low & standby_mode)
                                   | (~ext_ctrl_q.block_bit_mask_control
                                      & cpu_block_bit);
            core_ctrl_q.encode_on <= ext_ctrl_q.lvl;
            core_ctrl_q.level     <= ext_ctrl_q.lvl ? ~ext_s[3:0] : 4'h0;
        end
    end

    // summary interrupt: new requests set sticky status, write one clears
    assign grp    = {|port_request_q[15:8], |port_request_q[7:0]};
    assign events = {grp & ~grp_prev_q, ext_request_flag & ~flag_prev_q};

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flag_prev_q <= '0;
            grp_prev_q  <= 2'h0;
            stat_q      <= 8'h00;
        end else begin
            flag_prev_q <= ext_request_flag;
            grp_prev_q  <= grp;
            if (do_write && waddr_q == ext_irq_pkg::OFS_IRQ_STAT && wstrb_q[0]) begin
                stat_q <= (stat_q & ~wdata_q[7:0]) | events;
            end else begin
                stat_q <= stat_q | events;
            end
        end
    end

    assign irq = |(stat_q & mask_q);

    // read channel
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (araddr)
            ext_irq_pkg::OFS_EXT_CTRL:   rd_word[15:0] = ext_ctrl_q;
            ext_irq_pkg::OFS_PORT_SENSE: rd_word[15:0] = port_sense_q;
            ext_irq_pkg::OFS_PORT_EN:    rd_word[15:0] = port_en_q;
            ext_irq_pkg::OFS_REQ_FLAG:   rd_word[7:0]  = {grp, ext_request_flag};
            ext_irq_pkg::OFS_IRQ_STAT:   rd_word[7:0]  = stat_q;
            ext_irq_pkg::OFS_IRQ_MASK:   rd_word[7:0]  = mask_q;
            default:                     rd_hit        = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= ext_irq_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_hit ? ext_irq_pkg::RESP_OKAY : ext_irq_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence rise5_s;
        $rose(ext_s[5]) && ext_ctrl_q.sense[11:10] == ext_irq_pkg::SENSE_RISE;
    endsequence

    sequence high4_s;
        ext_ctrl_q.sense[9:8] == ext_irq_pkg::SENSE_HIGH && ext_s[4];
    endsequence

    reset_value_a: assert property ($rose(resetn) |->
        ext_ctrl_q == ext_irq_pkg::EXT_CTRL_RST && port_en_q == 16'h0000
        && port_sense_q == 16'h0000)
        else $error("control registers wrong after reset");
    reserved_zero_a: assert property (rvalid && $past(rd_take)
        && $past(araddr) == ext_irq_pkg::OFS_EXT_CTRL |-> rdata[12] == 1'b0)
        else $error("reserved control bit read as one");
    mask_all_a: assert property ($stable(ext_ctrl_q.mask_all_on_nmi_low) && !nmi_s
        |=> core_ctrl_q.mask_all == $past(ext_ctrl_q.mask_all_on_nmi_low))
        else $error("mask-all output does not follow control and nmi");
    nmi_mask_a: assert property (ext_ctrl_q.block_bit_mask_control
        && !(ext_ctrl_q.mask_all_on_nmi_low && standby_mode) |=> !core_ctrl_q.nmi_mask)
        else $error("nmi masked although block-bit mask control set");
    block_mask_a: assert property (!ext_ctrl_q.block_bit_mask_control && cpu_block_bit
        |=> core_ctrl_q.nmi_mask)
        else $error("nmi not masked while block bit set");
    encode_off_a: assert property (ext_ctrl_q.lvl [*2]
        |-> ext_request_flag[3:0] == 4'h0)
        else $error("encoded pins still raise independent flags");
    level_follow_a: assert property (high4_s |=> ext_request_flag[4])
        else $error("high level not reflected on flag");
    rise_edge_a: assert property (rise5_s |=> ext_request_flag[5])
        else $error("rising edge missed");
    edge_hold_a: assert property (ext_request_flag[5] && !ext_ctrl_q.sense[11]
        && !clr[5] |=> ext_request_flag[5])
        else $error("edge flag dropped without software clear");
    port_level_a: assert property (1'b1 |=> port_request_q
        == ($past(port_en_q) & ~($past(port_s) ^ $past(port_sense_q))))
        else $error("port request does not match sense and enable");

endmodule : ext_irq_detect_config

`default_nettype wire

// ==== verif/ext_src_model.sv ====
/*
 * Far side model: external request sources, port pins and cpu core levels.
 * Assumes the bench calls drive() and that levels are slow against clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

module ext_src_model (
    // clock
    input  wire logic clk_sys,
    // pins and core levels
    output logic [5:0]  ext_pins,
    output logic [15:0] port_pins,
    output logic        nmi_pin,
    output logic        cpu_block_bit,
    output logic        standby_mode
);
    initial begin
        ext_pins = 6'h00;
        port_pins = 16'h0000;
        {standby_mode, cpu_block_bit, nmi_pin} = 3'h1;
    end

    // levels change just after an edge and then hold for several cycles
    task automatic drive(input logic [5:0] e, input logic [15:0] p, input logic [2:0] c);
        @(posedge clk_sys);
        ext_pins <= e;
        port_pins <= p;
        {standby_mode, cpu_block_bit, nmi_pin} <= c;
    endtask : drive
endmodule : ext_src_model
`default_nettype wire

// ==== verif/tb_top.sv ====
/*
 * Self-checking bench for ext_irq_detect_config with a reference model.
 * Assumes the slave answers within a few cycles and pins settle in three edges.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic clk_sys = 1'b0;
    logic resetn;
    logic [7:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [5:0] ext_pins, ext_request_flag;
    logic [15:0] port_pins, port_request_q;
    logic nmi_pin, cpu_block_bit, standby_mode;
    ext_irq_pkg::core_ctrl_t core_ctrl_q;
    int bad_count = 0;
    int checked = 0;
    // reference model state
    logic [5:0] mflag = 6'h00, mpins = 6'h00;
    logic [11:0] msense = 12'h000;
    logic mlvl = 1'b1, mmai = 1'b0, mblm = 1'b0;
    logic [15:0] mport = 16'h0000, mps = 16'h0000, mpen = 16'h0000;
    logic [2:0] mctl = 3'h1;

    always #5 clk_sys = ~clk_sys;

    ext_irq_detect_config u_dut (
        .clk_sys(clk_sys), .resetn(resetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ext_request_pins(ext_pins), .port_interrupt_pins(port_pins),
        .nmi_pin(nmi_pin), .cpu_block_bit(cpu_block_bit),
        .standby_mode(standby_mode), .ext_request_flag(ext_request_flag),
        .port_request_q(port_request_q), .core_ctrl_q(core_ctrl_q), .irq(irq)
    );

    ext_src_model u_src (
        .clk_sys(clk_sys), .ext_pins(ext_pins), .port_pins(port_pins),
        .nmi_pin(nmi_pin), .cpu_block_bit(cpu_block_bit),
        .standby_mode(standby_mode)
    );

    task automatic final_report();
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ha, hw, hb;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            @(negedge clk_sys);
            ha = awvalid & awready;
            hw = wvalid & wready;
            hb = bvalid & bready;
            r = bresp;
            @(posedge clk_sys);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, hr;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hr = 1'b0;
        while (!hr) begin
            @(negedge clk_sys);
            ha = arvalid & arready;
            hr = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge clk_sys);
            if (ha) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : axr

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk("bresp", 32'h0, r);
    endtask : wr

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(nm, e, d);
        chk("rresp", 32'h0, r);
    endtask : rdchk

    task automatic check_all();
        @(negedge clk_sys);
        chk("flag", mlvl ? {mflag[5:4], 4'h0} : mflag, ext_request_flag);
        chk("port", mpen & ~(mport ^ mps), port_request_q);
        chk("core", {mmai & ~mctl[0], (mmai & mctl[2]) | (~mblm & mctl[1]), mlvl,
            mlvl ? ~mpins[3:0] : 4'h0}, core_ctrl_q);
    endtask : check_all

    task automatic set_ctrl(input logic ma, input logic lv, input logic bl, input logic [11:0] s);
        wr(ext_irq_pkg::OFS_EXT_CTRL, {16'h0, ma, lv, bl, 1'b0, s});
        {mmai, mlvl, mblm, msense} = {ma, lv, bl, s};
        for (int n = 0; n < 6; n++)
            if (msense[2*n+1]) mflag[n] = (mpins[n] == msense[2*n]);
    endtask : set_ctrl

    // a write alone leaves edge flags; a read of one then a zero write clears them
    task automatic clear_flags();
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] m;
        wr(ext_irq_pkg::OFS_REQ_FLAG, 32'h0);
        check_all();
        axr(ext_irq_pkg::OFS_REQ_FLAG, d, r);
        m = mpen & ~(mport ^ mps);
        chk("flags", {24'h0, |m[15:8], |m[7:0], mlvl ? {mflag[5:4], 4'h0} : mflag}, d);
        chk("rresp", 32'h0, r);
        wr(ext_irq_pkg::OFS_REQ_FLAG, 32'h0);
        for (int n = 0; n < 6; n++)
            if (!msense[2*n+1] && !(mlvl && n < 4)) mflag[n] = 1'b0;
        check_all();
    endtask : clear_flags

    task automatic pins(input logic [5:0] e, input logic [15:0] p, input logic [2:0] c);
        for (int n = 0; n < 6; n++)
            case (msense[2*n+:2])
                2'h0: if (mpins[n] & ~e[n]) mflag[n] = 1'b1;
                2'h1: if (~mpins[n] & e[n]) mflag[n] = 1'b1;
                default: mflag[n] = (e[n] == msense[2*n]);
            endcase
        {mpins, mport, mctl} = {e, p, c};
        u_src.drive(e, p, c);
        repeat (6) @(posedge clk_sys);
    endtask : pins

    initial begin
        logic [31:0] rv, d;
        logic [1:0] r;
        resetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr} = 16'h0000;
        wdata = 32'h0;
        wstrb = 4'hF;
        void'($urandom(69));
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        rdchk("ctrl_rst", ext_irq_pkg::OFS_EXT_CTRL, 32'h0000_4000);
        rdchk("psense_rst", ext_irq_pkg::OFS_PORT_SENSE, 32'h0);
        rdchk("pen_rst", ext_irq_pkg::OFS_PORT_EN, 32'h0);
        axw(8'h18, 32'hFFFF_FFFF, r);
        chk("bresp_unmapped", 32'h2, r);
        axr(8'h18, d, r);
        chk("rresp_unmapped", 32'h2, r);
        chk("rdata_unmapped", 32'h0, d);
        wr(ext_irq_pkg::OFS_EXT_CTRL, 32'hFFFF_FFFF);
        rdchk("ctrl_rsvd", ext_irq_pkg::OFS_EXT_CTRL, 32'h0000_EFFF);
        for (int i = 0; i < 12; i++) begin
            rv = $urandom;
            set_ctrl(rv[15], i >= 8, rv[13], rv[11:0]);
            mps = rv[31:16];
            wr(ext_irq_pkg::OFS_PORT_SENSE, {16'h0, mps});
            mpen = 16'($urandom);
            wr(ext_irq_pkg::OFS_PORT_EN, {16'h0, mpen});
            clear_flags();
            repeat (4) begin
                rv = $urandom;
                pins(rv[5:0], rv[21:6], rv[24:22]);
                check_all();
            end
            clear_flags();
        end
        set_ctrl(1'b0, 1'b0, 1'b0, 12'hFFF);
        mpen = 16'h0000;
        wr(ext_irq_pkg::OFS_PORT_EN, 32'h0);
        pins(6'h00, 16'h0000, 3'h1);
        wr(ext_irq_pkg::OFS_IRQ_STAT, 32'hFF);
        wr(ext_irq_pkg::OFS_IRQ_MASK, 32'h0);
        pins(6'h01, 16'h0000, 3'h1);
        check_all();
        chk("irq_masked", 32'h0, irq);
        rdchk("stat_set", ext_irq_pkg::OFS_IRQ_STAT, 32'h01);
        wr(ext_irq_pkg::OFS_IRQ_MASK, 32'h1);
        @(negedge clk_sys);
        chk("irq_on", 32'h1, irq);
        wr(ext_irq_pkg::OFS_IRQ_STAT, 32'h1);
        @(negedge clk_sys);
        chk("irq_off", 32'h0, irq);
        rdchk("stat_clr", ext_irq_pkg::OFS_IRQ_STAT, 32'h0);
        final_report();
    end

    initial begin
        #200000;
        bad_count++;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
